// >>> geie_pkg.sv
// Shared constants and types for the guest external interrupt exit/entry link
package geie_pkg;
   localparam int VEC_W = 8;
   localparam logic [15:0] EXIT_REASON_EXT_INT = 16'h0001;
   localparam logic [15:0] EXIT_REASON_INT_WINDOW = 16'h0007;
   localparam logic [15:0] EXIT_REASON_ENTRY_FAIL = 16'h0021;
   localparam logic [15:0] EXIT_REASON_RESET = 16'h0000;
   localparam logic [VEC_W-1:0] VECTOR_RESET = 8'h00;
   localparam int FRAME_WORDS = 2;
   localparam logic [1:0] EVT_TYPE_EXT_INT = 2'h0;
   typedef enum logic [4:0] {
      GEIE_ST_HOST = 5'b00001,
      GEIE_ST_GUEST = 5'b00010,
      GEIE_ST_ACK = 5'b00100,
      GEIE_ST_PUSH = 5'b01000,
      GEIE_ST_EXIT = 5'b10000
   } geie_state_type;
   typedef enum logic [3:0] {
      GEIE_HV_IDLE = 4'b0001,
      GEIE_HV_SERVICE = 4'b0010,
      GEIE_HV_WAIT = 4'b0100,
      GEIE_HV_ENTER = 4'b1000
   } geie_hv_state_type;
endpackage : geie_pkg

// >>> geie_if.sv
// Link between the guest-mode core logic and the hypervisor end
`timescale 1ns/100ps
interface geie_if
   import geie_pkg::*;
   (input wire logic clk_sys, input wire logic rst_b);
   // Controls held in the guest control structure
   logic ext_int_exit_ctl;
   logic ack_on_exit_ctl;
   logic int_window_exit_ctl;
   // Entry request with injected event
   logic entry_req;
   logic inject_valid;
   logic [VEC_W-1:0] inject_vector;
   // Guest interruptibility state
   logic guest_int_enable;
   logic instruction_shadow_blocking;
   logic stack_load_blocking;
   // Exit report
   logic exit_pulse;
   logic [15:0] exit_reason;
   logic exit_info_valid;
   logic [VEC_W-1:0] exit_vector;
   logic host_int_enable;
   logic in_guest;
   logic entry_done;
   modport core (
      input ext_int_exit_ctl, ack_on_exit_ctl, int_window_exit_ctl, entry_req, inject_valid,
      input inject_vector, guest_int_enable, instruction_shadow_blocking, stack_load_blocking,
      output exit_pulse, exit_reason, exit_info_valid, exit_vector, host_int_enable,
      output in_guest, entry_done
   );
   modport hyp (
      output ext_int_exit_ctl, ack_on_exit_ctl, int_window_exit_ctl, entry_req, inject_valid,
      output inject_vector, guest_int_enable, instruction_shadow_blocking, stack_load_blocking,
      input exit_pulse, exit_reason, exit_info_valid, exit_vector, host_int_enable,
      input in_guest, entry_done
   );
endinterface : geie_if

// >>> geie_core.sv
// Core-side guest exit and entry logic for external interrupts
`timescale 1ns/100ps
module geie_core
   import geie_pkg::*;
   (
   input wire logic clk_sys,
   input wire logic rst_b,
   geie_if.core link,
   input wire logic ext_int_pin,
   input wire logic host_sti,
   output logic int_ack,
   input wire logic ack_vector_valid,
   input wire logic [VEC_W-1:0] ack_vector,
   output logic gate_valid,
   output logic [VEC_W-1:0] gate_vector,
   output logic push_valid,
   output logic push_sel
   );

   ////////////////////////////////////////////////////////////////////////////
   geie_state_type state;
   geie_state_type next_state;
   logic int_sync1;
   logic int_sync2;
   logic guest_ready;
   logic [VEC_W-1:0] pending_vector;
   logic push_cnt;
   logic fail_hit;
   logic ext_hit;
   logic window_hit;

   assign guest_ready = link.guest_int_enable && !link.instruction_shadow_blocking
                        && !link.stack_load_blocking;

   // Injected event meeting a blocked guest refuses the entry
   assign fail_hit = (state == GEIE_ST_HOST) && link.entry_req && link.inject_valid
                     && !guest_ready;
   // Interrupt exit outranks the window exit
   assign ext_hit = (state == GEIE_ST_GUEST) && int_sync2 && link.ext_int_exit_ctl;
   assign window_hit = (state == GEIE_ST_GUEST) && link.int_window_exit_ctl && guest_ready
                       && !ext_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Gate select spans one descriptor table of 256 entries
   if (VEC_W != 8) begin : g_bad_vec_w
      $error("geie_core: vector width must be eight bits");
   end

   // One-bit push counter serves a two-word frame only
   if (FRAME_WORDS != 2) begin : g_bad_frame
      $error("geie_core: push counter serves two words only");
   end

   // Pin synchroniser
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         int_sync1 <= 1'b0;
         int_sync2 <= 1'b0;
      end else begin
         int_sync1 <= ext_int_pin;
         int_sync2 <= int_sync1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      case (state)
         GEIE_ST_HOST: begin
            if (link.entry_req) begin
               if (link.inject_valid && !guest_ready) begin
                  next_state = GEIE_ST_EXIT;
               end else if (link.inject_valid) begin
                  next_state = GEIE_ST_PUSH;
               end else begin
                  next_state = GEIE_ST_GUEST;
               end
            end
         end
         GEIE_ST_GUEST: begin
            if (int_sync2 && link.ext_int_exit_ctl) begin
               next_state = link.ack_on_exit_ctl ? GEIE_ST_ACK : GEIE_ST_EXIT;
            end else if (link.int_window_exit_ctl && guest_ready) begin
               next_state = GEIE_ST_EXIT;
            end
         end
         GEIE_ST_ACK: begin
            if (ack_vector_valid) begin
               next_state = GEIE_ST_EXIT;
            end
         end
         GEIE_ST_PUSH: begin
            if (push_cnt) begin
               next_state = GEIE_ST_GUEST;
            end
         end
         GEIE_ST_EXIT: begin
            next_state = GEIE_ST_HOST;
         end
         default: begin
            next_state = GEIE_ST_HOST;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state <= GEIE_ST_HOST;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Exit report: reason, and vector only on acknowledge-on-exit, recorded before control returns to host
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         link.exit_reason <= EXIT_REASON_RESET;
         link.exit_info_valid <= 1'b0;
         link.exit_vector <= VECTOR_RESET;
      end else if (fail_hit) begin
         link.exit_reason <= EXIT_REASON_ENTRY_FAIL;
         link.exit_info_valid <= 1'b0;
      end else if (ext_hit) begin
         link.exit_reason <= EXIT_REASON_EXT_INT;
         link.exit_info_valid <= 1'b0;
      end else if (window_hit) begin
         link.exit_reason <= EXIT_REASON_INT_WINDOW;
         link.exit_info_valid <= 1'b0;
      end else if (state == GEIE_ST_ACK && ack_vector_valid) begin
         link.exit_vector <= ack_vector;
         link.exit_info_valid <= 1'b1;
      end
   end

   // Interrupt acknowledge request held until the vector returns
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         int_ack <= 1'b0;
      end else begin
         int_ack <= (next_state == GEIE_ST_ACK);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         link.exit_pulse <= 1'b0;
         link.in_guest <= 1'b0;
         link.entry_done <= 1'b0;
      end else begin
         link.exit_pulse <= (state == GEIE_ST_EXIT);
         link.in_guest <= (next_state == GEIE_ST_GUEST) || (next_state == GEIE_ST_PUSH)
                          || (next_state == GEIE_ST_ACK);
         link.entry_done <= (state == GEIE_ST_HOST) && link.entry_req;
      end
   end

   // Host flag cleared on every exit, set again only by host software
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         link.host_int_enable <= 1'b0;
      end else if (state == GEIE_ST_EXIT) begin
         link.host_int_enable <= 1'b0;
      end else if (state == GEIE_ST_HOST && host_sti) begin
         link.host_int_enable <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Single event latched per entry; gate select and two-word stack push
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pending_vector <= VECTOR_RESET;
         gate_valid <= 1'b0;
         gate_vector <= VECTOR_RESET;
         push_cnt <= 1'b0;
         push_valid <= 1'b0;
         push_sel <= 1'b0;
      end else begin
         gate_valid <= 1'b0;
         push_valid <= 1'b0;
         if (state == GEIE_ST_HOST && link.entry_req && link.inject_valid && guest_ready) begin
            pending_vector <= link.inject_vector;
            gate_valid <= 1'b1;
            gate_vector <= link.inject_vector;
            push_cnt <= 1'b0;
         end else if (state == GEIE_ST_PUSH) begin
            push_valid <= 1'b1;
            push_sel <= push_cnt;
            push_cnt <= ~push_cnt;
            gate_vector <= pending_vector;
         end
      end
   end

endmodule : geie_core

// >>> geie_hyp.sv
// Hypervisor end: masks source, issues end-of-interrupt, queues and injects
`timescale 1ns/100ps
module geie_hyp
   import geie_pkg::*;
   (
   input wire logic clk_sys,
   input wire logic rst_b,
   geie_if.hyp link,
   input wire logic cfg_ext_exit,
   input wire logic cfg_ack_exit,
   input wire logic cfg_window_exit,
   input wire logic virt_req,
   input wire logic [VEC_W-1:0] virt_vector,
   input wire logic virt_level,
   input wire logic vctrl_accept,
   input wire logic g_if,
   input wire logic g_shadow,
   input wire logic g_stack,
   output logic src_mask,
   output logic eoi_write,
   output logic queued
   );

   geie_hv_state_type state;
   logic [VEC_W-1:0] q_vector;
   logic ready;

   assign ready = g_if && !g_shadow && !g_stack && vctrl_accept;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state <= GEIE_HV_IDLE;
         q_vector <= VECTOR_RESET;
         queued <= 1'b0;
         src_mask <= 1'b0;
         eoi_write <= 1'b0;
         link.entry_req <= 1'b0;
         link.inject_valid <= 1'b0;
         link.inject_vector <= VECTOR_RESET;
      end else begin
         eoi_write <= 1'b0;
         link.entry_req <= 1'b0;
         case (state)
            GEIE_HV_IDLE: begin
               if (virt_req && !link.in_guest) begin
                  q_vector <= virt_vector;
                  queued <= 1'b1;
                  src_mask <= virt_level;
                  eoi_write <= 1'b1;
                  state <= GEIE_HV_SERVICE;
               end
            end
            GEIE_HV_SERVICE: begin
               state <= GEIE_HV_WAIT;
            end
            GEIE_HV_WAIT: begin
               if (ready && !link.in_guest) begin
                  link.inject_vector <= q_vector;
                  link.inject_valid <= 1'b1;
                  state <= GEIE_HV_ENTER;
               end
            end
            GEIE_HV_ENTER: begin
               link.entry_req <= 1'b1;
               queued <= 1'b0;
               state <= GEIE_HV_IDLE;
            end
            default: begin
               state <= GEIE_HV_IDLE;
            end
         endcase
         if (link.entry_done) begin
            link.inject_valid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         link.ext_int_exit_ctl <= 1'b0;
         link.ack_on_exit_ctl <= 1'b0;
         link.int_window_exit_ctl <= 1'b0;
         link.guest_int_enable <= 1'b0;
         link.instruction_shadow_blocking <= 1'b0;
         link.stack_load_blocking <= 1'b0;
      end else begin
         link.ext_int_exit_ctl <= cfg_ext_exit;
         link.ack_on_exit_ctl <= cfg_ack_exit;
         // Dropped one cycle after the link shows ready, so the core sees both
         link.int_window_exit_ctl <= cfg_window_exit && !(link.guest_int_enable
                                     && !link.instruction_shadow_blocking
                                     && !link.stack_load_blocking);
         link.guest_int_enable <= g_if;
         link.instruction_shadow_blocking <= g_shadow;
         link.stack_load_blocking <= g_stack;
      end
   end

endmodule : geie_hyp

// >>> geie_chk.sv
// Checker on the link between core end and hypervisor end
`timescale 1ns/100ps
module geie_chk
   import geie_pkg::*;
   (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ack_on_exit_ctl,
   input wire logic int_window_exit_ctl,
   input wire logic entry_req,
   input wire logic inject_valid,
   input wire logic guest_int_enable,
   input wire logic instruction_shadow_blocking,
   input wire logic stack_load_blocking,
   input wire logic exit_pulse,
   input wire logic [15:0] exit_reason,
   input wire logic exit_info_valid,
   input wire logic host_int_enable,
   input wire logic in_guest,
   input wire logic entry_done
   );
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   wire logic ready = guest_int_enable && !instruction_shadow_blocking && !stack_load_blocking;
   wire logic ext_exit = exit_pulse && exit_reason == EXIT_REASON_EXT_INT;
   ////////////////////////////////////////////////////////////////
   sequence s_done;
      entry_done ##1 !entry_done;
   endsequence
   sequence s_fail;
      exit_reason == EXIT_REASON_ENTRY_FAIL ##1 exit_pulse;
   endsequence
   property p_leave; ext_exit |-> $past(in_guest, 2) && !in_guest; endproperty
   a_leave: assert property (p_leave) else $error("exit without leaving guest");
   property p_mask; exit_pulse |-> !host_int_enable; endproperty
   a_mask: assert property (p_mask) else $error("enable flag set on exit");
   property p_reason; exit_pulse && exit_info_valid |-> exit_reason == 16'h0001; endproperty
   a_reason: assert property (p_reason) else $error("wrong exit reason");
   property p_ack; ext_exit && ack_on_exit_ctl |-> exit_info_valid; endproperty
   a_ack: assert property (p_ack) else $error("vector not saved");
   property p_sti; $rose(host_int_enable) |-> !in_guest; endproperty
   a_sti: assert property (p_sti) else $error("enable flag set in guest");
   property p_ready; $rose(inject_valid) |-> ready; endproperty
   a_ready: assert property (p_ready) else $error("injection into blocked guest");
   property p_window; in_guest && int_window_exit_ctl && ready |-> ##[1:6] exit_pulse; endproperty
   a_window: assert property (p_window) else $error("no window exit");
   property p_entry; entry_req && !in_guest |=> s_done; endproperty
   a_entry: assert property (p_entry) else $error("entry not answered once");
   property p_fail; entry_req && !in_guest && inject_valid && !ready |=> s_fail; endproperty
   a_fail: assert property (p_fail) else $error("blocked entry did not fail");
   property p_info; entry_req && inject_valid |-> $past(inject_valid); endproperty
   a_info: assert property (p_info) else $error("info written with resume");
endmodule : geie_chk

// >>> guest_external_interrupt_exit_entry_tb.sv
// Testbench joining core end and hypervisor end
`timescale 1ns/100ps
module guest_external_interrupt_exit_entry_tb;
   import geie_pkg::*;
   logic clk_sys = 1'b0, rst_b = 1'b0, ext_int_pin = 1'b0, host_sti = 1'b0;
   logic ack_vector_valid = 1'b0, cfg_ext_exit = 1'b1, cfg_ack_exit = 1'b0;
   logic cfg_window_exit = 1'b0, virt_req = 1'b0, virt_level = 1'b1, vctrl_accept = 1'b1;
   logic g_if = 1'b1, g_shadow = 1'b0, g_stack = 1'b0, saw_mask = 1'b0, saw_eoi = 1'b0;
   logic [VEC_W-1:0] ack_vector = 8'h00, virt_vector = 8'h00, gate_vector;
   logic int_ack, gate_valid, push_valid, push_sel, src_mask, eoi_write, queued;
   int fail_count = 0, n_checks = 0, k;
   always #5 clk_sys = ~clk_sys;
   geie_if lk (.clk_sys(clk_sys), .rst_b(rst_b));
   geie_core u_geie_core (.clk_sys(clk_sys), .rst_b(rst_b), .link(lk.core),
      .ext_int_pin(ext_int_pin), .host_sti(host_sti), .int_ack(int_ack),
      .ack_vector_valid(ack_vector_valid), .ack_vector(ack_vector), .gate_valid(gate_valid),
      .gate_vector(gate_vector), .push_valid(push_valid), .push_sel(push_sel));
   geie_hyp u_geie_hyp (.clk_sys(clk_sys), .rst_b(rst_b), .link(lk.hyp),
      .cfg_ext_exit(cfg_ext_exit), .cfg_ack_exit(cfg_ack_exit), .cfg_window_exit(cfg_window_exit),
      .virt_req(virt_req), .virt_vector(virt_vector), .virt_level(virt_level),
      .vctrl_accept(vctrl_accept), .g_if(g_if), .g_shadow(g_shadow), .g_stack(g_stack),
      .src_mask(src_mask), .eoi_write(eoi_write), .queued(queued));
   geie_chk u_geie_chk (.clk_sys(clk_sys), .rst_b(rst_b),
      .ack_on_exit_ctl(lk.ack_on_exit_ctl), .int_window_exit_ctl(lk.int_window_exit_ctl),
      .entry_req(lk.entry_req), .inject_valid(lk.inject_valid),
      .guest_int_enable(lk.guest_int_enable),
      .instruction_shadow_blocking(lk.instruction_shadow_blocking),
      .stack_load_blocking(lk.stack_load_blocking), .exit_pulse(lk.exit_pulse),
      .exit_reason(lk.exit_reason), .exit_info_valid(lk.exit_info_valid),
      .host_int_enable(lk.host_int_enable), .in_guest(lk.in_guest), .entry_done(lk.entry_done));
   always @(posedge clk_sys) begin
      if (src_mask === 1'b1) saw_mask <= 1'b1;
      if (eoi_write === 1'b1) saw_eoi <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////
   task tick;
      @(posedge clk_sys);
      #1;
   endtask : tick
   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task send(input logic [VEC_W-1:0] v);
      @(posedge clk_sys);
      virt_vector <= v;
      virt_req <= 1'b1;
      @(posedge clk_sys);
      virt_req <= 1'b0;
      #1;
   endtask : send
   task land(input logic [VEC_W-1:0] v);
      for (k = 0; k < 60 && gate_valid !== 1'b1; k++) tick();
      check({7'h00, gate_valid, gate_vector}, {8'h01, v});
      check({14'h0, saw_mask, saw_eoi}, 16'h0003);
      tick();
      check({13'h0, gate_valid, push_valid, push_sel}, 16'h0002);
      tick();
      check({14'h0, push_valid, push_sel}, 16'h0003);
      for (k = 0; k < 10 && lk.in_guest !== 1'b1; k++) tick();
      check({15'h0, lk.in_guest}, 16'h0001);
   endtask : land
   task ext_exit(input logic ack);
      @(posedge clk_sys);
      ext_int_pin <= 1'b1;
      if (ack) begin
         for (k = 0; k < 20 && int_ack !== 1'b1; k++) tick();
         check({15'h0, int_ack}, 16'h0001);
         @(posedge clk_sys);
         ack_vector_valid <= 1'b1;
         ack_vector <= 8'h3c;
         @(posedge clk_sys);
         ack_vector_valid <= 1'b0;
      end
      #1;
      for (k = 0; k < 20 && lk.exit_pulse !== 1'b1; k++) tick();
      check(lk.exit_reason, 16'h0001);
      check({15'h0, lk.host_int_enable}, 16'h0000);
      check({15'h0, lk.in_guest}, 16'h0000);
      if (ack) check({7'h00, lk.exit_info_valid, lk.exit_vector}, 16'h013c);
      @(posedge clk_sys);
      ext_int_pin <= 1'b0;
   endtask : ext_exit
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      tick();
      check(lk.exit_reason, EXIT_REASON_RESET);
      check({15'h0, lk.in_guest}, 16'h0000);
      send(8'h42);
      land(8'h42);
      ext_exit(1'b0);
      @(posedge clk_sys);
      host_sti <= 1'b1;
      repeat (3) tick();
      check({15'h0, lk.host_int_enable}, 16'h0001);
      $display("test 1 done");
      @(posedge clk_sys);
      host_sti <= 1'b0;
      cfg_ack_exit <= 1'b1;
      send(8'h55);
      land(8'h55);
      ext_exit(1'b1);
      $display("test 2 done");
      @(posedge clk_sys);
      g_shadow <= 1'b1;
      send(8'h61);
      repeat (10) tick();
      check({14'h0, queued, lk.in_guest}, 16'h0002);
      @(posedge clk_sys);
      g_shadow <= 1'b0;
      land(8'h61);
      $display("test 3 done");
      @(posedge clk_sys);
      g_shadow <= 1'b1;
      cfg_window_exit <= 1'b1;
      repeat (4) tick();
      check({14'h0, lk.int_window_exit_ctl, lk.in_guest}, 16'h0003);
      @(posedge clk_sys);
      g_shadow <= 1'b0;
      for (k = 0; k < 10 && lk.exit_pulse !== 1'b1; k++) tick();
      check(lk.exit_reason, EXIT_REASON_INT_WINDOW);
      check({14'h0, lk.in_guest, lk.host_int_enable}, 16'h0000);
      @(posedge clk_sys);
      cfg_window_exit <= 1'b0;
      $display("test 4 done");
      send(8'h24);
      repeat (2) @(posedge clk_sys);
      g_shadow <= 1'b1;
      for (k = 0; k < 10 && lk.exit_pulse !== 1'b1; k++) tick();
      check(lk.exit_reason, EXIT_REASON_ENTRY_FAIL);
      check({13'h0, gate_valid, lk.in_guest, lk.host_int_enable}, 16'h0000);
      @(posedge clk_sys);
      g_shadow <= 1'b0;
      $display("test 5 done");
      close_out();
   end
   initial begin
      #20000;
      fail_count++;
      close_out();
   end
endmodule : guest_external_interrupt_exit_entry_tb
